//--- shared/flash_ctrl_pkg.sv
package flash_ctrl_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ADDR_W = 8;

    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_UNLOCK_KEY = 8'h04;
    localparam logic [7:0] OFF_TABLE_PAGE = 8'h08;
    localparam logic [7:0] OFF_TABLE_POINTER = 8'h0c;
    localparam logic [7:0] OFF_TABLE_LOW_WORD = 8'h10;
    localparam logic [7:0] OFF_TABLE_HIGH_BYTE = 8'h14;

    localparam int BIT_START = 15;
    localparam int BIT_WRITE_ENABLE = 14;
    localparam int BIT_SEQ_ERROR = 13;
    localparam int BIT_ERASE_SELECT = 6;
    localparam int OP_CODE_LSB = 0;
    localparam int OP_CODE_W = 4;

    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [7:0] TABLE_PAGE_RESET = 8'h00;
    localparam logic [15:0] TABLE_POINTER_RESET = 16'h0000;

    localparam logic [3:0] OP_BULK = 4'hf;
    localparam logic [3:0] OP_WORD = 4'h3;
    localparam logic [3:0] OP_PAGE = 4'h2;
    localparam logic [3:0] OP_ROW = 4'h1;

    localparam logic [7:0] KEY_FIRST_VALUE = 8'h55;
    localparam logic [7:0] KEY_SECOND_VALUE = 8'haa;

    localparam int ROW_WORDS = 64;
    localparam int ROWS_PER_PAGE = 8;
    localparam int LATCH_W = 24;
    localparam int FLASH_ADDR_W = 24;
    localparam int ROW_ADDR_BITS = 7;
    localparam int PAGE_ADDR_BITS = 10;

    // Self-timed durations, microseconds
    localparam int WORD_PROG_US = 20;
    localparam int ROW_PROG_US = 2000;
    localparam int PAGE_ERASE_US = 2000;
    localparam int BULK_ERASE_US = 20000;

    function automatic int cycles_from_us(input int us);
        return (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction

    localparam int WORD_PROG_CYCLES = cycles_from_us(WORD_PROG_US);
    localparam int ROW_PROG_CYCLES = cycles_from_us(ROW_PROG_US);
    localparam int PAGE_ERASE_CYCLES = cycles_from_us(PAGE_ERASE_US);
    localparam int BULK_ERASE_CYCLES = cycles_from_us(BULK_ERASE_US);

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_WORD,
        CMD_ROW,
        CMD_PAGE,
        CMD_BULK
    } flash_cmd_t;
endpackage

//--- rtl/holding_latches.sv
`timescale 1ns/1ps
module holding_latches
    import flash_ctrl_pkg::*;
#(
    parameter int WIDTH = LATCH_W,
    parameter int DEPTH = ROW_WORDS
)(
    input wire logic i_sys_clk,
    input wire logic i_wr_low,
    input wire logic i_wr_high,
    input wire logic [$clog2(DEPTH)-1:0] i_widx,
    input wire logic [15:0] i_wdata,
    input wire logic [$clog2(DEPTH)-1:0] i_ridx,
    output logic [WIDTH-1:0] o_rdata
);
    // No reset: the latches power up unknown, software fills unused slots
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge i_sys_clk)
    begin
        if (i_wr_low)
            mem[i_widx][15:0] <= i_wdata;
        if (i_wr_high)
            mem[i_widx][WIDTH-1:16] <= i_wdata[WIDTH-17:0];
        o_rdata <= mem[i_ridx];
    end
endmodule

//--- rtl/flash_program_erase_control.sv
// Operation
// [R1] Setting start launches the selected operation; hardware times it and clears start.
// [R2] Software can set start but not clear it; zero means idle.
// [R3] Operations run only with the write enable bit set.
// [R4] Every start attempt that is rejected sets the sequence error flag.
// [R5] Erase select picks the erase or program variant of the code.
// [R6] Code 1111 bulk erases with erase select, serial mode only.
// [R7] Code 0011 programs one word when erase select is zero.
// [R8] Code 0010 erases one eight-row page when erase select is one.
// [R9] Code 0001 programs a full row from the latches, erase select zero.
// [R10] Other codes are unimplemented and perform nothing.
// [R11] Unused control bits read zero and ignore writes.
// [R12] Software erases and merges the eight-row block before programming a row.
// [R13] For block erase software sets code, erase, enable, page and pointer.
// [R14] Keys 55h then AAh must directly precede the start write.
// [R15] The core stalls for the whole operation until start clears.
// [R16] Software places two no-ops after setting start.
// [R17] Software loads 64 latch words per row, repeating over 512 words.
// [R18] Table writes fill holding latches, committed only by a program run.
// [R19] Key register is write-only; both keys on consecutive writes.
// [R20] A row is 64 words; erase blocks are eight aligned rows.
// [R21] Start without enable and fresh keys begins nothing and changes no flash.
// [R22] A no-operation combination clears start within a few cycles.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module flash_program_erase_control
    import flash_ctrl_pkg::*;
#(
    parameter int unsigned WORD_CYCLES = WORD_PROG_CYCLES,
    parameter int unsigned ROW_CYCLES = ROW_PROG_CYCLES,
    parameter int unsigned PAGE_CYCLES = PAGE_ERASE_CYCLES,
    parameter int unsigned BULK_CYCLES = BULK_ERASE_CYCLES
)(
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_serial_prog_mode,
    output logic o_core_stall,
    output logic o_flash_strobe,
    output logic [2:0] o_flash_cmd,
    output logic [FLASH_ADDR_W-1:0] o_flash_addr,
    output logic [LATCH_W-1:0] o_flash_wdata
);
    typedef enum logic [1:0] {KEY_IDLE, KEY_FIRST, KEY_ARMED} key_state_t;
    typedef enum logic [2:0] {S_IDLE, S_FETCH, S_ISSUE, S_WAIT, S_DONE} seq_state_t;

    function automatic flash_cmd_t decode_op(input logic [3:0] code, input logic erase,
                                             input logic serial);
        case (code)
            OP_BULK: decode_op = (erase && serial) ? CMD_BULK : CMD_NONE; // [R6]
            OP_WORD: decode_op = erase ? CMD_NONE : CMD_WORD; // [R7]
            OP_PAGE: decode_op = erase ? CMD_PAGE : CMD_NONE; // [R8]
            OP_ROW: decode_op = erase ? CMD_NONE : CMD_ROW; // [R9]
            default: decode_op = CMD_NONE; // [R10]
        endcase
    endfunction

    function automatic logic [31:0] duration_of(input flash_cmd_t cmd);
        case (cmd)
            CMD_WORD: duration_of = 32'(WORD_CYCLES);
            CMD_ROW: duration_of = 32'(ROW_CYCLES);
            CMD_PAGE: duration_of = 32'(PAGE_CYCLES);
            CMD_BULK: duration_of = 32'(BULK_CYCLES);
            default: duration_of = 32'h0000_0001;
        endcase
    endfunction

    logic start_ff, nxt_start;
    logic op_write_enable_ff;
    logic error_ff, nxt_error;
    logic erase_ff;
    logic [3:0] op_ff;
    logic [7:0] page_ff;
    logic [15:0] pointer_ff;
    key_state_t key_ff, nxt_key;
    seq_state_t state_ff, nxt_state;
    flash_cmd_t cmd_ff;
    logic [5:0] idx_ff;
    logic [31:0] timer_ff;
    logic [FLASH_ADDR_W-1:0] base_ff;
    logic pready_ff, pslverr_ff, stall_ff, strobe_ff;
    logic [31:0] prdata_ff;
    logic [2:0] fcmd_ff;
    logic [FLASH_ADDR_W-1:0] faddr_ff;
    logic [LATCH_W-1:0] fwdata_ff;
    logic serial_s1_ff, serial_s2_ff, serial_s3_ff, serial_ff;
    logic [LATCH_W-1:0] latch_rdata;

    // APB decode: one wait state so that every answer comes from a register
    wire access = i_psel && i_penable;
    wire commit = access && pready_ff;
    wire apb_write = commit && i_pwrite;
    wire hit_ctrl = i_paddr == OFF_CONTROL;
    wire hit_key = i_paddr == OFF_UNLOCK_KEY;
    wire hit_page = i_paddr == OFF_TABLE_PAGE;
    wire hit_ptr = i_paddr == OFF_TABLE_POINTER;
    wire hit_low = i_paddr == OFF_TABLE_LOW_WORD;
    wire hit_high = i_paddr == OFF_TABLE_HIGH_BYTE;
    wire mapped = hit_ctrl || hit_key || hit_page || hit_ptr || hit_low || hit_high;
    wire busy = start_ff;

    // Control writes are ignored while an operation runs; the core is stalled anyway
    wire wr_ctrl = apb_write && hit_ctrl && !busy;
    wire start_try = wr_ctrl && i_pwdata[BIT_START];
    wire start_ok = start_try && i_pwdata[BIT_WRITE_ENABLE] && key_ff == KEY_ARMED; // [R3] [R14] [R21]
    wire start_reject = start_try && !start_ok;
    wire [FLASH_ADDR_W-1:0] table_addr = {page_ff, pointer_ff};
    wire flash_cmd_t new_cmd = decode_op(i_pwdata[OP_CODE_LSB +: OP_CODE_W],
                                         i_pwdata[BIT_ERASE_SELECT], serial_ff); // [R5]
    wire [FLASH_ADDR_W-1:0] row_base = {table_addr[FLASH_ADDR_W-1:ROW_ADDR_BITS],
                                        ROW_ADDR_BITS'(0)};
    wire [FLASH_ADDR_W-1:0] page_base = {table_addr[FLASH_ADDR_W-1:PAGE_ADDR_BITS],
                                         PAGE_ADDR_BITS'(0)}; // [R20]
    wire [5:0] table_idx = table_addr[ROW_ADDR_BITS-1:1];
    wire last_word = cmd_ff != CMD_ROW || idx_ff == 6'(ROW_WORDS - 1);
    wire latch_wr_low = apb_write && hit_low && !busy; // [R18]
    wire latch_wr_high = apb_write && hit_high && !busy; // [R18]

    wire [15:0] ctrl_view = {start_ff, op_write_enable_ff, error_ff, 6'h00, erase_ff, 2'h0, op_ff}; // [R11]
    wire [31:0] read_mux = hit_ctrl ? {16'h0000, ctrl_view} :
                           hit_page ? {24'h000000, page_ff} :
                           hit_ptr ? {16'h0000, pointer_ff} : 32'h0000_0000; // [R19]

    holding_latches #(
        .WIDTH(LATCH_W),
        .DEPTH(ROW_WORDS)
    ) u_latches (
        .i_sys_clk(i_sys_clk),
        .i_wr_low(latch_wr_low),
        .i_wr_high(latch_wr_high),
        .i_widx(table_idx),
        .i_wdata(i_pwdata[15:0]),
        .i_ridx(idx_ff),
        .o_rdata(latch_rdata)
    );

    // Unlock keys: any other write in between disarms the sequence
    always_comb
    begin
        nxt_key = KEY_IDLE;
        if (!apb_write)
            nxt_key = key_ff;
        else if (hit_key && i_pwdata[7:0] == KEY_FIRST_VALUE)
            nxt_key = KEY_FIRST; // [R19]
        else if (hit_key && i_pwdata[7:0] == KEY_SECOND_VALUE && key_ff == KEY_FIRST)
            nxt_key = KEY_ARMED; // [R14] [R19]
    end

    always_comb
    begin
        nxt_error = error_ff;
        if (state_ff == S_DONE)
            nxt_error = 1'b0; // [R4]
        else if (wr_ctrl)
            nxt_error = i_pwdata[BIT_SEQ_ERROR];
        if (start_reject)
            nxt_error = 1'b1; // [R4]
    end

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE:
                if (start_ok)
                begin
                    if (new_cmd == CMD_NONE)
                        nxt_state = S_DONE; // [R22]
                    else if (new_cmd == CMD_PAGE || new_cmd == CMD_BULK)
                        nxt_state = S_ISSUE;
                    else
                        nxt_state = S_FETCH;
                end
            S_FETCH: nxt_state = S_ISSUE;
            S_ISSUE: nxt_state = last_word ? S_WAIT : S_FETCH;
            S_WAIT: nxt_state = (timer_ff == 32'h0000_0000) ? S_DONE : S_WAIT;
            S_DONE: nxt_state = S_IDLE;
            default: nxt_state = S_IDLE;
        endcase
    end

    // Software only sets start; hardware clears it on the way out of S_DONE
    assign nxt_start = (state_ff == S_DONE) ? 1'b0 : (start_ff || start_ok); // [R1] [R2]

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            serial_s1_ff <= 1'b0;
            serial_s2_ff <= 1'b0;
            serial_s3_ff <= 1'b0;
            serial_ff <= 1'b0;
        end
        else
        begin
            serial_s1_ff <= i_serial_prog_mode;
            serial_s2_ff <= serial_s1_ff;
            serial_s3_ff <= serial_s2_ff;
            if (serial_s2_ff == serial_s3_ff)
                serial_ff <= serial_s3_ff;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            start_ff <= CONTROL_RESET[BIT_START];
            op_write_enable_ff <= CONTROL_RESET[BIT_WRITE_ENABLE];
            error_ff <= CONTROL_RESET[BIT_SEQ_ERROR];
            erase_ff <= CONTROL_RESET[BIT_ERASE_SELECT];
            op_ff <= CONTROL_RESET[OP_CODE_LSB +: OP_CODE_W];
            page_ff <= TABLE_PAGE_RESET;
            pointer_ff <= TABLE_POINTER_RESET;
            key_ff <= KEY_IDLE;
        end
        else
        begin
            start_ff <= nxt_start;
            error_ff <= nxt_error;
            key_ff <= nxt_key;
            if (wr_ctrl)
            begin
                op_write_enable_ff <= i_pwdata[BIT_WRITE_ENABLE];
                erase_ff <= i_pwdata[BIT_ERASE_SELECT];
                op_ff <= i_pwdata[OP_CODE_LSB +: OP_CODE_W];
            end
            if (apb_write && hit_page && !busy)
                page_ff <= i_pwdata[7:0];
            if (apb_write && hit_ptr && !busy)
                pointer_ff <= i_pwdata[15:0];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            state_ff <= S_IDLE;
            cmd_ff <= CMD_NONE;
            idx_ff <= 6'h00;
            timer_ff <= 32'h0000_0000;
            base_ff <= 24'h000000;
        end
        else
        begin
            state_ff <= nxt_state;
            if (state_ff == S_IDLE && start_ok)
            begin
                cmd_ff <= new_cmd;
                idx_ff <= (new_cmd == CMD_WORD) ? table_idx : 6'h00;
                base_ff <= (new_cmd == CMD_PAGE) ? page_base :
                           (new_cmd == CMD_ROW) ? row_base : table_addr; // [R13]
            end
            if (state_ff == S_ISSUE && !last_word)
                idx_ff <= idx_ff + 6'h01; // [R9]
            if (state_ff == S_ISSUE)
                timer_ff <= duration_of(cmd_ff) - 32'h0000_0001; // [R1]
            else if (state_ff == S_WAIT && timer_ff != 32'h0000_0000)
                timer_ff <= timer_ff - 32'h0000_0001;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            strobe_ff <= 1'b0;
            fcmd_ff <= 3'h0;
            faddr_ff <= 24'h000000;
            fwdata_ff <= 24'h000000;
            stall_ff <= 1'b0;
        end
        else
        begin
            strobe_ff <= state_ff == S_ISSUE;
            stall_ff <= nxt_start; // [R15]
            if (state_ff == S_ISSUE)
            begin
                fcmd_ff <= cmd_ff;
                faddr_ff <= (cmd_ff == CMD_ROW || cmd_ff == CMD_WORD) ?
                            {base_ff[FLASH_ADDR_W-1:ROW_ADDR_BITS], idx_ff, base_ff[0]} :
                            base_ff;
                fwdata_ff <= latch_rdata; // [R18]
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end
        else
        begin
            pready_ff <= access && !pready_ff;
            pslverr_ff <= access && !pready_ff && !mapped;
            if (access && !pready_ff)
                prdata_ff <= i_pwrite ? 32'h0000_0000 : read_mux;
        end
    end

    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_core_stall = stall_ff;
    assign o_flash_strobe = strobe_ff;
    assign o_flash_cmd = fcmd_ff;
    assign o_flash_addr = faddr_ff;
    assign o_flash_wdata = fwdata_ff;
endmodule

//--- sim/flash_pec_sva.sv
`timescale 1ns/1ps
module flash_pec_sva
    import flash_ctrl_pkg::*;
#(
    parameter int unsigned WORD_CYCLES = 5,
    parameter int unsigned PAGE_CYCLES = 20
)(
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_serial_prog_mode,
    input wire logic o_core_stall,
    input wire logic o_flash_strobe,
    input wire logic [2:0] o_flash_cmd,
    input wire logic [FLASH_ADDR_W-1:0] o_flash_addr,
    input wire logic [LATCH_W-1:0] o_flash_wdata
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    logic [31:0] gap_ff;
    wire start_wr = i_psel && i_penable && o_pready && i_pwrite && i_paddr == OFF_CONTROL;
    // Cycles since the last flash strobe, to bound the self-timed wait
    always_ff @(posedge i_sys_clk or posedge i_reset)
        if (i_reset) gap_ff <= '0;
        else if (o_flash_strobe) gap_ff <= '0;
        else gap_ff <= gap_ff + 32'h1;
    ready_wait_a: assert property (i_psel && i_penable && !$past(i_penable) |-> !o_pready ##1 o_pready)
        else $error("pready not on second access cycle");
    ready_pulse_a: assert property (o_pready |=> !o_pready) else $error("pready longer than one cycle");
    slverr_ready_a: assert property (o_pslverr |-> o_pready) else $error("pslverr without pready");
    stall_cause_a: assert property ($rose(o_core_stall) |-> $past(start_wr && i_pwdata[15] && i_pwdata[14]))
        else $error("operation began without an enabled start write");
    strobe_stall_a: assert property (o_flash_strobe |-> o_core_stall)
        else $error("flash strobe outside a stalled operation");
    strobe_pulse_a: assert property (o_flash_strobe |=> !o_flash_strobe)
        else $error("strobe held for two cycles");
    first_step_a: assert property ($rose(o_core_stall) |-> ##[1:4] (o_flash_strobe || !o_core_stall))
        else $error("operation made no progress");
    cmd_legal_a: assert property (o_flash_strobe |-> o_flash_cmd inside {3'h1, 3'h2, 3'h3, 3'h4})
        else $error("strobe with undefined command");
    page_align_a: assert property (o_flash_strobe && o_flash_cmd == 3'h3 |-> o_flash_addr[9:0] == 10'h000)
        else $error("page erase not block aligned");
    bulk_serial_a: assert property (o_flash_strobe && o_flash_cmd == 3'h4 |-> i_serial_prog_mode)
        else $error("bulk erase outside serial mode");
    word_time_a: assert property ($fell(o_core_stall) && o_flash_cmd == 3'h1 |-> gap_ff >= WORD_CYCLES)
        else $error("word program ended early");
    page_time_a: assert property ($fell(o_core_stall) && o_flash_cmd == 3'h3 |-> gap_ff >= PAGE_CYCLES)
        else $error("page erase ended early");
    word_c: cover property (o_flash_strobe && o_flash_cmd == 3'h1);
    row_c: cover property (o_flash_strobe && o_flash_cmd == 3'h2);
    err_c: cover property (o_pslverr);
endmodule
bind flash_program_erase_control flash_pec_sva #(.WORD_CYCLES(WORD_CYCLES), .PAGE_CYCLES(PAGE_CYCLES)) chk (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_serial_prog_mode(i_serial_prog_mode),
    .o_core_stall(o_core_stall), .o_flash_strobe(o_flash_strobe), .o_flash_cmd(o_flash_cmd),
    .o_flash_addr(o_flash_addr), .o_flash_wdata(o_flash_wdata));

//--- sim/core_model.sv
`timescale 1ns/1ps
module core_model
    import flash_ctrl_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic [31:0] i_prdata,
    input wire logic i_pready,
    input wire logic i_pslverr,
    input wire logic i_core_stall,
    output logic o_psel,
    output logic o_penable,
    output logic o_pwrite,
    output logic [ADDR_W-1:0] o_paddr,
    output logic [31:0] o_pwdata
);
    initial
    begin
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = '0;
        o_pwdata = '0;
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge i_sys_clk);
        o_psel <= 1'b1;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_sys_clk);
        o_penable <= 1'b1;
        // No cycle count assumed: only the bench watchdog ends a hung wait
        n = 0;
        do
        begin
            @(posedge i_sys_clk);
            n++;
        end
        while (i_pready !== 1'b1);
        r = i_prdata;
        e = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        // Released lines show garbage, so nobody may rely on stale values
        o_paddr <= ~a;
        o_pwdata <= ~d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        bus(1'b1, a, d, r, e);
    endtask
    task automatic run_op(input logic [15:0] ctrl, output int cyc);
        wr(OFF_CONTROL, {16'h0000, ctrl});
        wr(OFF_UNLOCK_KEY, {24'h000000, KEY_FIRST_VALUE});
        wr(OFF_UNLOCK_KEY, {24'h000000, KEY_SECOND_VALUE});
        wr(OFF_CONTROL, {16'h0000, ctrl | 16'h8000});
        repeat (2) @(posedge i_sys_clk);
        cyc = 2;
        // The core issues nothing while stalled
        while (i_core_stall !== 1'b0)
        begin
            @(posedge i_sys_clk);
            cyc++;
        end
    endtask
endmodule

//--- sim/flash_program_erase_control_tb.sv
`timescale 1ns/1ps
module flash_program_erase_control_tb;
    import flash_ctrl_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, serial, stall, strobe, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic [2:0] cmd;
    logic [23:0] faddr, fdata;
    logic [23:0] log_addr[64];
    logic [23:0] log_data[64];
    int n_strobe, cyc, fail_count, num_checks;
    logic [15:0] nops[6] = '{16'h4043, 16'h4041, 16'h4002, 16'h400f, 16'h4005, 16'h404f};
    flash_program_erase_control #(.WORD_CYCLES(5), .ROW_CYCLES(20), .PAGE_CYCLES(20),
        .BULK_CYCLES(30)) dut (.i_sys_clk(clk), .i_reset(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_serial_prog_mode(serial), .o_core_stall(stall), .o_flash_strobe(strobe),
        .o_flash_cmd(cmd), .o_flash_addr(faddr), .o_flash_wdata(fdata));
    core_model core (.i_sys_clk(clk), .i_prdata(prdata), .i_pready(pready),
        .i_pslverr(pslverr), .i_core_stall(stall), .o_psel(psel), .o_penable(penable),
        .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
        if (strobe === 1'b1)
        begin
            if (n_strobe < 64) log_addr[n_strobe] = faddr;
            if (n_strobe < 64) log_data[n_strobe] = fdata;
            n_strobe++;
        end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a);
        core.bus(1'b0, a, 32'h0, v, err);
    endtask
    task automatic t_map;
        rd(OFF_CONTROL);
        check("control reset", v, 32'h0);
        rd(8'h18);
        check("unmapped data", v, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        rd(OFF_UNLOCK_KEY);
        check("key readback", v, 32'h0);
        core.wr(OFF_CONTROL, 32'h00007fff);
        rd(OFF_CONTROL);
        check("unused bits", v, 32'h0000604f);
    endtask
    task automatic t_reject;
        n_strobe = 0;
        core.run_op(16'h0003, cyc);
        rd(OFF_CONTROL);
        check("start without enable", v, 32'h00002003);
        core.wr(OFF_CONTROL, 32'h00004003);
        core.wr(OFF_CONTROL, 32'h0000c003);
        rd(OFF_CONTROL);
        check("start without keys", v, 32'h00006003);
        check("rejected strobes", n_strobe, 0);
    endtask
    task automatic t_word;
        n_strobe = 0;
        core.wr(OFF_TABLE_PAGE, 32'h01);
        core.wr(OFF_TABLE_POINTER, 32'h0010);
        core.wr(OFF_TABLE_LOW_WORD, 32'h1234);
        core.wr(OFF_TABLE_HIGH_BYTE, 32'h56);
        check("latch held", n_strobe, 0);
        core.run_op(16'h4003, cyc);
        check("word strobes", n_strobe, 1);
        check("word cmd", cmd, 3'h1);
        check("word addr", log_addr[0], 24'h010010);
        check("word data", log_data[0], 24'h561234);
        check("word timed", cyc >= 5, 1);
        rd(OFF_CONTROL);
        check("word done", v, 32'h00004003);
    endtask
    task automatic t_nop;
        for (int k = 0; k < 6; k++)
        begin
            n_strobe = 0;
            core.run_op(nops[k], cyc);
            check("nop strobes", n_strobe, 0);
            check("nop quick", cyc < 10, 1);
            rd(OFF_CONTROL);
            check("nop start", v & 32'h8000, 32'h0);
        end
    endtask
    task automatic t_erase;
        n_strobe = 0;
        core.wr(OFF_TABLE_PAGE, 32'h02);
        core.wr(OFF_TABLE_POINTER, 32'h0123);
        core.run_op(16'h4042, cyc);
        check("page cmd", cmd, 3'h3);
        check("page addr", log_addr[0], 24'h020000);
        check("page timed", cyc >= 20, 1);
        serial <= 1'b1;
        repeat (6) @(posedge clk);
        core.run_op(16'h404f, cyc);
        check("bulk cmd", cmd, 3'h4);
        check("erase strobes", n_strobe, 2);
        serial <= 1'b0;
    endtask
    task automatic t_row;
        core.wr(OFF_TABLE_PAGE, 32'h00);
        for (int i = 0; i < 64; i++)
        begin
            core.wr(OFF_TABLE_POINTER, 2 * i);
            core.wr(OFF_TABLE_LOW_WORD, 32'h0000a000 | i);
            core.wr(OFF_TABLE_HIGH_BYTE, 32'h80 | i);
        end
        n_strobe = 0;
        core.run_op(16'h4001, cyc);
        check("row strobes", n_strobe, ROW_WORDS);
        check("row cmd", cmd, 3'h2);
        for (int i = 0; i < 64; i++)
        begin
            check("row addr", log_addr[i], 2 * i);
            check("row data", log_data[i], {8'h80 | 8'(i), 16'ha000 | 16'(i)});
        end
    endtask
    initial
    begin
        rst = 1'b1;
        serial = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_map();
        t_reject();
        t_word();
        t_nop();
        t_erase();
        t_row();
        results();
    end
    initial
    begin
        #200000;
        fail_count++;
        results();
    end
endmodule
